// ---- pkg/pfs_defs.svh ----
// Summary of operation
// [R1] Overcurrent threshold selectable in eleven steps from 50 to 140 percent of rating.
// [R2] Overvoltage threshold 110 to 130 percent in 10 percent steps, default 130.
// [R3] Effective overvoltage trip level never falls below 1.0 volt.
// [R4] Undervoltage threshold 75 to 85 percent in 5 percent steps, default 75.
// [R5] Voltage, temperature and tracking faults request turn-off about 6 us after crossing.
// [R6] Shut down above 130 C; restart allowed only once down to 120 C. When latched, a rearm while still hot clears the thermal off for one cycle.
// [R7] Tracking, when enabled, checked only during ramp-up; trips beyond 250 mV deviation.
// [R8] Warning flag sets at 120 C and clears 3 C below that.
// [R9] Warning rises no sooner than about 6 us after exceeding its threshold.
// [R10] Power-good high inside window: lower 90 or 95 percent, upper 110 percent.
// [R11] Power-good output follows a window crossing after about 6 us.
// [R12] Each protection latching or retrying every 130 ms; default non-latching.
// [R13] Tracking protection off after power-up; same latching choices when enabled.
`ifndef PFS_DEFS_SVH
`define PFS_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define PFS_OFS_CFG     5'h00
`define PFS_OFS_SETPT   5'h04
`define PFS_OFS_RATED   5'h08
`define PFS_OFS_STATUS  5'h0C
`define PFS_OFS_MASK    5'h10
`define PFS_OFS_LIVE    5'h14

// ****************************************
// Configuration reset values and fields
// ****************************************
`define PFS_CFG_RST     32'h0000_0020
`define PFS_SETPT_RST   16'h01F4
`define PFS_RATED_RST   16'h4E20
`define PFS_NPROT       5
`define PFS_NEVT        8

// ****************************************
// Threshold scales (percent, mV, degrees C)
// ****************************************
`define PFS_OC_BASE     8'h32
`define PFS_OC_STEP     8'h09
`define PFS_OC_MAXSTEP  4'hA
`define PFS_OV_BASE     8'h6E
`define PFS_OV_STEP     8'h0A
`define PFS_UV_BASE     8'h4B
`define PFS_UV_STEP     8'h05
`define PFS_STEP_MAX2   2'h2
`define PFS_PG_LO_BASE  8'h5A
`define PFS_PG_LO_STEP  8'h05
`define PFS_PG_HI_PCT   8'h6E
`define PFS_OV_FLOOR_X100 24'h0186A0
`define PFS_TRK_MV      17'h000FA
`define PFS_OT_OFF_C    10'h082
`define PFS_OT_ON_C     10'h078
`define PFS_WARN_C      10'h078
`define PFS_WARN_HYS_C  10'h003

// ****************************************
// Timing
// ****************************************
`define PFS_CLK_NS      4
`define PFS_FILT_NS     6000
`define PFS_FILT_CYC    (`PFS_FILT_NS / `PFS_CLK_NS)
`define PFS_OC_CYC      1
`define PFS_RETRY_MS    130
`define PFS_RETRY_CYC   ((`PFS_RETRY_MS * 1000000) / `PFS_CLK_NS)

`endif

// ---- pkg/pfs_pkg.sv ----
package pfs_pkg;

	// Measurements from the sensing path
	typedef struct packed {
		logic [15:0]        vout_mv;
		logic [15:0]        iout_ma;
		logic signed [9:0]  temp_c;
		logic [15:0]        ref_mv;
		logic               ramp_up;
	} pfs_meas_t;

	// Software configuration word
	typedef struct packed {
		logic [16:0] unused;
		logic [4:0]  latch;
		logic        track_en;
		logic        pg_lo_step;
		logic [1:0]  uv_step;
		logic [1:0]  ov_step;
		logic [3:0]  oc_step;
	} pfs_cfg_t;

	// Fault response states, one-hot
	typedef enum logic [2:0] {
		PFS_RUN   = 3'h1,
		PFS_HOLD  = 3'h2,
		PFS_LATCH = 3'h4
	} pfs_state_t;

endpackage : pfs_pkg

// ---- hdl/pfs_filt.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Stability filter: output follows input after DLY steady cycles
// ****************************************
module pfs_filt #(
	parameter int DLY = 1500
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic level_in,
	output logic      level_out
);
	logic [$clog2(DLY+1)-1:0] cnt;

	// Any bounce restarts the count, so glitches never pass
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt       <= '0;
			level_out <= 1'b0;
		end else if (level_in == level_out) begin
			cnt <= '0;
		end else if (cnt == ($clog2(DLY+1))'(DLY - 1)) begin
			cnt       <= '0;
			level_out <= level_in;
		end else begin
			cnt <= cnt + 1'b1;
		end
	end
endmodule : pfs_filt
`default_nettype wire

// ---- hdl/pfs_resp.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Fault response: latch off or retry on a fixed period
// ****************************************
module pfs_resp #(
	parameter int RETRY_CYC = 32500000
) (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic fault,
	input  wire logic latching,
	input  wire logic rearm,
	output logic      off,
	output logic      trip
);
	localparam int CW = $clog2(RETRY_CYC + 1);
	pfs_pkg::pfs_state_t state;
	pfs_pkg::pfs_state_t next_state;
	logic [CW-1:0]       cnt;
	logic                cnt_done;

	assign cnt_done = (cnt == CW'(RETRY_CYC - 1));

	// Next state; a fault still present at retry time restarts the wait
	always_comb begin
		next_state = state;
		case (state)
			pfs_pkg::PFS_RUN: begin
				if (fault)
					next_state = latching ? pfs_pkg::PFS_LATCH : pfs_pkg::PFS_HOLD; // see [R12]
			end
			pfs_pkg::PFS_HOLD: begin
				if (cnt_done && !fault)
					next_state = pfs_pkg::PFS_RUN; // see [R12]
			end
			pfs_pkg::PFS_LATCH: begin
				if (rearm)
					next_state = pfs_pkg::PFS_RUN; // see [R12]
			end
			default: next_state = pfs_pkg::PFS_RUN;
		endcase
	end

	// State, off flag and trip pulse
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= pfs_pkg::PFS_RUN;
			off   <= 1'b0;
			trip  <= 1'b0;
		end else begin
			state <= next_state;
			off   <= (next_state != pfs_pkg::PFS_RUN);
			trip  <= (state == pfs_pkg::PFS_RUN) && (next_state != pfs_pkg::PFS_RUN);
		end
	end

	// Retry period counter, runs only while holding off
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			cnt <= '0;
		else if (state != pfs_pkg::PFS_HOLD || cnt_done)
			cnt <= '0;
		else
			cnt <= cnt + 1'b1;
	end
endmodule : pfs_resp
`default_nettype wire

// ---- hdl/pfs_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pfs_defs.svh"
// ****************************************
// Point-of-load fault supervisor
// ****************************************
module pfs_top #(
	parameter int RETRY_CYC = `PFS_RETRY_CYC,
	parameter int FILT_CYC  = `PFS_FILT_CYC,
	parameter int OC_CYC    = `PFS_OC_CYC
) (
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	input  wire pfs_pkg::pfs_meas_t meas,
	input  wire logic [4:0]        avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	output logic                   turn_off_req,
	output logic                   power_good_out,
	output logic                   ot_warn,
	output logic                   irq
);
	// ****************************************
	// Helper functions
	// ****************************************

	// Scale a millivolt or milliamp value by a percentage (x100 domain)
	function automatic logic [23:0] mul_pct(
		input logic [15:0] val,
		input logic [7:0]  pct
	);
		mul_pct = 24'(val) * 24'(pct);
	endfunction : mul_pct

	// Scale a value by 100 so it compares against mul_pct results
	function automatic logic [23:0] x100(
		input logic [15:0] val
	);
		x100 = 24'(val) * 24'h000064;
	endfunction : x100

	// Byte-lane merge for writes
	function automatic logic [31:0] be_merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (be[i])
				r[i*8 +: 8] = new_v[i*8 +: 8];
		end
		be_merge = r;
	endfunction : be_merge

	// ****************************************
	// Register state
	// ****************************************
	pfs_pkg::pfs_cfg_t       cfg;
	logic [15:0]             setpt_mv;
	logic [15:0]             rated_ma;
	logic [`PFS_NEVT-1:0]    status;
	logic [`PFS_NEVT-1:0]    mask;
	logic                    wr_ack;
	logic                    rd_ack;
	logic                    rearm;
	logic [`PFS_NEVT-1:0]    evt;

	assign wr_ack = avs_write && !avs_waitrequest;
	assign rd_ack = avs_read && !avs_waitrequest;

	// ****************************************
	// Threshold computation
	// ****************************************
	logic [7:0]  oc_pct;
	logic [7:0]  ov_pct;
	logic [7:0]  uv_pct;
	logic [7:0]  pg_lo_pct;
	logic [3:0]  oc_step_c;
	logic [1:0]  ov_step_c;
	logic [1:0]  uv_step_c;
	logic [23:0] ov_lvl;
	logic [23:0] ov_lvl_raw;
	logic [23:0] vout_x;

	// Out-of-range steps clamp to the top step rather than wrapping
	assign oc_step_c = (cfg.oc_step > `PFS_OC_MAXSTEP) ? `PFS_OC_MAXSTEP : cfg.oc_step;
	assign ov_step_c = (cfg.ov_step > `PFS_STEP_MAX2) ? `PFS_STEP_MAX2 : cfg.ov_step;
	assign uv_step_c = (cfg.uv_step > `PFS_STEP_MAX2) ? `PFS_STEP_MAX2 : cfg.uv_step;

	// Percent per setting
	assign oc_pct    = `PFS_OC_BASE + 8'(oc_step_c) * `PFS_OC_STEP;         // see [R1]
	assign ov_pct    = `PFS_OV_BASE + 8'(ov_step_c) * `PFS_OV_STEP;         // see [R2]
	assign uv_pct    = `PFS_UV_BASE + 8'(uv_step_c) * `PFS_UV_STEP;         // see [R4]
	assign pg_lo_pct = `PFS_PG_LO_BASE + (cfg.pg_lo_step ? `PFS_PG_LO_STEP : 8'h00); // see [R10]

	// Overvoltage level floored at one volt for low setpoints
	assign ov_lvl_raw = mul_pct(setpt_mv, ov_pct);
	assign ov_lvl     = (ov_lvl_raw < `PFS_OV_FLOOR_X100) ? `PFS_OV_FLOOR_X100 : ov_lvl_raw; // see [R3]
	assign vout_x     = x100(meas.vout_mv);

	// ****************************************
	// Raw comparators
	// ****************************************
	logic               oc_raw;
	logic               overvoltage_trip;
	logic               uv_raw;
	logic               trk_raw;
	logic               power_window_ok;
	logic               ot_hot;
	logic               warn_hot;
	logic signed [16:0] trk_dev;

	assign oc_raw           = x100(meas.iout_ma) > mul_pct(rated_ma, oc_pct); // see [R1]
	assign overvoltage_trip = vout_x > ov_lvl;                               // see [R2]
	assign uv_raw           = vout_x < mul_pct(setpt_mv, uv_pct);             // see [R4]

	// Window check for power good
	assign power_window_ok = (vout_x >= mul_pct(setpt_mv, pg_lo_pct))
		&& (vout_x <= mul_pct(setpt_mv, `PFS_PG_HI_PCT));                  // see [R10]

	// Tracking looked at only during ramp-up and only if enabled
	assign trk_dev = $signed({1'b0, meas.vout_mv}) - $signed({1'b0, meas.ref_mv});
	assign trk_raw = cfg.track_en && meas.ramp_up
		&& ((trk_dev > $signed(`PFS_TRK_MV))
		|| (trk_dev < -$signed(`PFS_TRK_MV))); // see [R7] [R13]

	// Shutdown hysteresis: hot above 130 C, cool again at 120 C
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			ot_hot <= 1'b0;
		else if (meas.temp_c > $signed(`PFS_OT_OFF_C))
			ot_hot <= 1'b1; // see [R6]
		else if (meas.temp_c <= $signed(`PFS_OT_ON_C))
			ot_hot <= 1'b0; // see [R6]
	end

	// Warning comparator, always running with 3 C hysteresis
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			warn_hot <= 1'b0;
		else if (meas.temp_c >= $signed(`PFS_WARN_C))
			warn_hot <= 1'b1; // see [R8]
		else if (meas.temp_c <= $signed(`PFS_WARN_C - `PFS_WARN_HYS_C))
			warn_hot <= 1'b0; // see [R8]
	end

	// ****************************************
	// Delay filters
	// ****************************************
	logic [`PFS_NPROT-1:0] raw_vec;
	logic [`PFS_NPROT-1:0] flt_vec;
	logic                  warn_flt;
	logic                  pg_flt;

	// Order: overcurrent, overvoltage, undervoltage, overtemperature, tracking
	assign raw_vec = {
		trk_raw,
		ot_hot,
		uv_raw,
		overvoltage_trip,
		oc_raw
	};

	// Overcurrent has no stated delay, so it uses its own short count
	pfs_filt #(.DLY(OC_CYC)) u_filt_oc (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.level_in  (raw_vec[0]),
		.level_out (flt_vec[0])
	);

	// Six microsecond filters on the other protections
	generate
		for (genvar g = 1; g < `PFS_NPROT; g++) begin : g_filt
			pfs_filt #(.DLY(FILT_CYC)) u_filt (
				.clk_sys   (clk_sys),
				.rst_n     (rst_n),
				.level_in  (raw_vec[g]),
				.level_out (flt_vec[g])
			); // see [R5]
		end
	endgenerate

	// Warning filter holds off the flag for the full delay
	pfs_filt #(.DLY(FILT_CYC)) u_filt_warn (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.level_in  (warn_hot),
		.level_out (warn_flt)
	); // see [R9]

	// Power-good window filter, both directions
	pfs_filt #(.DLY(FILT_CYC)) u_filt_pg (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.level_in  (power_window_ok),
		.level_out (pg_flt)
	); // see [R11]

	// ****************************************
	// Fault responses
	// ****************************************
	logic [`PFS_NPROT-1:0] off_vec;
	logic [`PFS_NPROT-1:0] trip_vec;

	// One response engine per protection; cooling gates the thermal retry, a rearm releases a latched thermal trip for one cycle even when hot
	generate
		for (genvar g = 0; g < `PFS_NPROT; g++) begin : g_resp
			pfs_resp #(.RETRY_CYC(RETRY_CYC)) u_resp (
				.clk_sys  (clk_sys),
				.rst_n    (rst_n),
				.fault    (flt_vec[g]),
				.latching (cfg.latch[g]),
				.rearm    (rearm),
				.off      (off_vec[g]),
				.trip     (trip_vec[g])
			); // see [R12] [R6]
		end
	endgenerate

	// ****************************************
	// Outputs
	// ****************************************
	logic warn_q;
	logic pg_q;

	// Turn-off request, warning and power good from flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			turn_off_req   <= 1'b0;
			ot_warn        <= 1'b0;
			power_good_out <= 1'b0;
		end else begin
			turn_off_req   <= |off_vec;  // see [R5]
			ot_warn        <= warn_flt;  // see [R8]
			power_good_out <= pg_flt;    // see [R10]
		end
	end

	// Previous levels for edge events
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			warn_q <= 1'b0;
			pg_q   <= 1'b0;
		end else begin
			warn_q <= warn_flt;
			pg_q   <= pg_flt;
		end
	end

	// Event vector: trips, warning rise, power-good fall and rise
	assign evt = {
		pg_flt & ~pg_q,
		~pg_flt & pg_q,
		warn_flt & ~warn_q,
		trip_vec
	};

	// ****************************************
	// Avalon-MM slave
	// ****************************************

	// One wait cycle per access; keeps readdata registered
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			avs_waitrequest <= 1'b1;
		else if ((avs_read || avs_write) && avs_waitrequest)
			avs_waitrequest <= 1'b0;
		else
			avs_waitrequest <= 1'b1;
	end

	// Configuration writes; any write to it rearms latched faults
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg      <= pfs_pkg::pfs_cfg_t'(`PFS_CFG_RST); // see [R2] [R4] [R13]
			setpt_mv <= `PFS_SETPT_RST;
			rated_ma <= `PFS_RATED_RST;
			mask     <= '0;
			rearm    <= 1'b0;
		end else begin
			rearm <= 1'b0;
			if (wr_ack && avs_address == `PFS_OFS_CFG) begin
				cfg   <= pfs_pkg::pfs_cfg_t'(be_merge(32'(cfg), avs_writedata, avs_byteenable));
				rearm <= 1'b1; // see [R12]
			end else if (wr_ack && avs_address == `PFS_OFS_SETPT) begin
				setpt_mv <= 16'(be_merge(32'(setpt_mv), avs_writedata, avs_byteenable));
			end else if (wr_ack && avs_address == `PFS_OFS_RATED) begin
				rated_ma <= 16'(be_merge(32'(rated_ma), avs_writedata, avs_byteenable));
			end else if (wr_ack && avs_address == `PFS_OFS_MASK) begin
				mask <= `PFS_NEVT'(be_merge(32'(mask), avs_writedata, avs_byteenable));
			end
		end
	end

	// Sticky status, cleared by read; a same-cycle event survives the clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			status <= '0;
		else if (rd_ack && avs_address == `PFS_OFS_STATUS)
			status <= evt;
		else
			status <= status | evt;
	end

	// Read data latched while waitrequest is still high
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			avs_readdata <= '0;
		end else if (avs_read && avs_waitrequest) begin
			if (avs_address == `PFS_OFS_CFG)
				avs_readdata <= 32'(cfg);
			else if (avs_address == `PFS_OFS_SETPT)
				avs_readdata <= 32'(setpt_mv);
			else if (avs_address == `PFS_OFS_RATED)
				avs_readdata <= 32'(rated_ma);
			else if (avs_address == `PFS_OFS_STATUS)
				avs_readdata <= 32'(status);
			else if (avs_address == `PFS_OFS_MASK)
				avs_readdata <= 32'(mask);
			else if (avs_address == `PFS_OFS_LIVE)
				avs_readdata <= 32'({
					turn_off_req,
					power_good_out,
					ot_warn,
					off_vec
				});
			else
				avs_readdata <= '0;
		end
	end

	// Level interrupt from unmasked sticky bits
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n)
			irq <= 1'b0;
		else
			irq <= |(status & mask);
	end
endmodule : pfs_top
`default_nettype wire

// ---- verif/pfs_stage.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Power stage and sensing path model
// ****************************************
module pfs_stage (
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	input  wire pfs_pkg::pfs_meas_t target,
	output var  pfs_pkg::pfs_meas_t meas
);
	// Sampled sensing: each reading lands one cycle late, zero while held in reset
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			meas <= '0;
		end else begin
			meas <= target;
		end
	end
endmodule : pfs_stage
`default_nettype wire

// ---- verif/pfs_props.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Timing checker at the supervisor ports
// ****************************************
module pfs_props #(
	parameter int RETRY_CYC = 200,
	parameter int FILT_CYC  = 20,
	parameter int OC_CYC    = 1
) (
	input wire logic               clk_sys,
	input wire logic               rst_n,
	input wire pfs_pkg::pfs_meas_t meas,
	input wire logic [4:0]         avs_address,
	input wire logic               avs_read,
	input wire logic               avs_write,
	input wire logic [31:0]        avs_writedata,
	input wire logic               avs_waitrequest,
	input wire logic               turn_off_req,
	input wire logic               power_good_out,
	input wire logic               ot_warn
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	pfs_pkg::pfs_cfg_t cfg;
	logic [15:0]       setpt, rated;
	logic [31:0]       v100, oc_lim, ov_lim;
	logic              pg_in, pg_q, ov_hi, oc_hi;
	int                pg_cnt, ov_cnt, oc_cnt, off_cnt, warn_cnt;
	// Shadow of the threshold registers; assumes full-word writes
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cfg   <= pfs_pkg::pfs_cfg_t'(32'h20);
			setpt <= 16'h01F4;
			rated <= 16'h4E20;
		end else if (avs_write && !avs_waitrequest) begin
			if (avs_address == 5'h00) cfg <= pfs_pkg::pfs_cfg_t'(avs_writedata);
			if (avs_address == 5'h04) setpt <= avs_writedata[15:0];
			if (avs_address == 5'h08) rated <= avs_writedata[15:0];
		end
	end
	// Raw comparisons in hundredths, so percentages stay exact
	always_comb begin
		v100   = 32'(meas.vout_mv) * 32'h64;
		oc_lim = 32'(rated) * (32'h32 + 32'h9 * ((cfg.oc_step > 4'hA) ? 32'hA : 32'(cfg.oc_step)));
		ov_lim = 32'(setpt) * (32'h6E + 32'hA * ((cfg.ov_step > 2'h2) ? 32'h2 : 32'(cfg.ov_step)));
		if (ov_lim < 32'h186A0) ov_lim = 32'h186A0; // Floor at one volt
		pg_in  = v100 >= 32'(setpt) * (cfg.pg_lo_step ? 32'h5F : 32'h5A);
		pg_in  = pg_in && (v100 <= 32'(setpt) * 32'h6E);
		ov_hi  = v100 > ov_lim;
		oc_hi  = 32'(meas.iout_ma) * 32'h64 > oc_lim;
	end
	function automatic int sat(input int c, input logic on);
		return on ? ((c < 1000) ? c + 1 : c) : 0;
	endfunction : sat
	// Run-length counters; saturate so long idle stretches cannot wrap
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pg_q     <= 1'b0;
			pg_cnt   <= 0;
			ov_cnt   <= 0;
			oc_cnt   <= 0;
			off_cnt  <= 0;
			warn_cnt <= 0;
		end else begin
			pg_q     <= pg_in;
			pg_cnt   <= sat(pg_cnt, pg_in == pg_q);
			ov_cnt   <= sat(ov_cnt, ov_hi);
			oc_cnt   <= sat(oc_cnt, oc_hi);
			off_cnt  <= sat(off_cnt, turn_off_req);
			warn_cnt <= sat(warn_cnt, meas.temp_c >= $signed(10'h078));
		end
	end
	sequence s_one_wait;
		avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_bus_wait: assert property ($rose(avs_read || avs_write) |-> s_one_wait)
		else $error("waitrequest not low for exactly one cycle");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> avs_waitrequest)
		else $error("waitrequest low with no request");
	a_pg_settled: assert property (pg_cnt >= FILT_CYC + 4 |-> power_good_out == pg_q)
		else $error("power good does not match window");
	a_pg_early: assert property ($changed(power_good_out) |-> pg_cnt >= FILT_CYC - 4)
		else $error("power good moved before settling");
	a_ov_trip: assert property (ov_cnt >= FILT_CYC + 5 |-> turn_off_req)
		else $error("overvoltage not turned off");
	a_oc_trip: assert property (oc_cnt >= OC_CYC + 4 |-> turn_off_req)
		else $error("overcurrent not turned off");
	a_retry_min: assert property ($fell(turn_off_req) |-> off_cnt >= RETRY_CYC - 2)
		else $error("restart before retry period");
	a_warn_early: assert property ($rose(ot_warn) |-> warn_cnt >= FILT_CYC - 4)
		else $error("warning raised too early");
endmodule : pfs_props
bind pfs_top pfs_props #(.RETRY_CYC(RETRY_CYC), .FILT_CYC(FILT_CYC), .OC_CYC(OC_CYC)) u_pfs_props (
	.clk_sys(clk_sys), .rst_n(rst_n), .meas(meas), .avs_address(avs_address),
	.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
	.avs_waitrequest(avs_waitrequest), .turn_off_req(turn_off_req),
	.power_good_out(power_good_out), .ot_warn(ot_warn));
`default_nettype wire

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Supervisor testbench
// ****************************************
module testbench;
	typedef struct packed {
		logic [15:0] v;
		logic [15:0] i;
		logic [9:0]  t;
		logic [2:0]  e;
	} pfs_row_t;
	localparam int F = 20;
	localparam int R = 200;
	logic               clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
	logic               turn_off_req, power_good_out, ot_warn, irq;
	logic [4:0]         avs_address;
	logic [31:0]        avs_writedata, avs_readdata, rd;
	pfs_pkg::pfs_meas_t target, meas;
	pfs_row_t           rows [16];
	int                 fail_count, checks_done;
	pfs_stage u_pfs_stage (.clk_sys(clk_sys), .rst_n(rst_n), .target(target), .meas(meas));
	pfs_top #(.RETRY_CYC(R), .FILT_CYC(F), .OC_CYC(1)) u_pfs_top (.clk_sys(clk_sys),
		.rst_n(rst_n), .meas(meas), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.turn_off_req(turn_off_req), .power_good_out(power_good_out), .ot_warn(ot_warn),
		.irq(irq));
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	// One Avalon transfer; request held until waitrequest is sampled low
	task automatic bus(input logic [4:0] a, input logic wr, input logic [31:0] d);
		int n;
		n = 0;
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		@(posedge clk_sys);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			n++;
			@(posedge clk_sys);
		end
		rd = avs_readdata;
		if (n == 20) begin
			fail_count++;
			$display("Error at %0t: bus timeout", $time);
			end_of_test();
		end
		avs_write <= 1'b0;
		avs_read  <= 1'b0;
		@(posedge clk_sys);
	endtask : bus
	task automatic put(input logic [15:0] v, input logic [15:0] i, input logic [9:0] t,
		input logic [15:0] rf, input logic rp);
		target <= '{v, i, t, rf, rp};
	endtask : put
	// 250 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Rows give {turn-off, power good, warning} after settling, default thresholds
	initial begin
		rows = '{'{16'h01F4, 16'h1388, 10'h019, 3'h2}, '{16'h02BC, 16'h1388, 10'h019, 3'h0},
			'{16'h03E9, 16'h1388, 10'h019, 3'h4}, '{16'h01F4, 16'h2710, 10'h019, 3'h2},
			'{16'h01F4, 16'h2711, 10'h019, 3'h6}, '{16'h0176, 16'h1388, 10'h019, 3'h4},
			'{16'h0177, 16'h1388, 10'h019, 3'h0}, '{16'h01C2, 16'h1388, 10'h019, 3'h2},
			'{16'h01C1, 16'h1388, 10'h019, 3'h0}, '{16'h0226, 16'h1388, 10'h019, 3'h2},
			'{16'h0227, 16'h1388, 10'h019, 3'h0}, '{16'h01F4, 16'h1388, 10'h078, 3'h3},
			'{16'h01F4, 16'h1388, 10'h083, 3'h7}, '{16'h01F4, 16'h1388, 10'h07D, 3'h7},
			'{16'h01F4, 16'h1388, 10'h076, 3'h3}, '{16'h01F4, 16'h1388, 10'h075, 3'h2}};
		fail_count = 0;
		checks_done = 0;
		rst_n = 1'b0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		target = '{16'h01F4, 16'h1388, 10'h019, 16'h0000, 1'b0};
		cyc(20);
		rst_n <= 1'b1;
		cyc(1);
		// Each row held long enough for a retry period to elapse
		for (int k = 0; k < 16; k++) begin
			put(rows[k].v, rows[k].i, rows[k].t, 16'h0000, 1'b0);
			cyc(300);
			chk({turn_off_req, power_good_out, ot_warn}, rows[k].e, "row");
		end
		$display("threshold rows done");
		// Reset in mid-run, then defaults read back
		rst_n <= 1'b0;
		cyc(3);
		chk({avs_waitrequest, turn_off_req, power_good_out, ot_warn, irq}, 5'h10, "reset pins");
		rst_n <= 1'b1;
		cyc(F - 3);
		chk(power_good_out, 1'b0, "pg before filter");
		cyc(10);
		chk(power_good_out, 1'b1, "pg after filter");
		bus(5'h00, 1'b0, 32'h0);
		chk(rd, 32'h20, "cfg default");
		bus(5'h04, 1'b0, 32'h0);
		chk(rd, 32'h1F4, "setpoint default");
		bus(5'h08, 1'b0, 32'h0);
		chk(rd, 32'h4E20, "rating default");
		bus(5'h10, 1'b0, 32'h0);
		chk(rd, 32'h0, "mask default");
		bus(5'h18, 1'b0, 32'h0);
		chk(rd, 32'h0, "unmapped");
		$display("reset test done");
		// 140 percent current, 110 percent OV latching, 85 percent UV, 95 percent pg
		bus(5'h0C, 1'b0, 32'h0);
		bus(5'h10, 1'b1, 32'h2);
		bus(5'h04, 1'b1, 32'h3E8);
		bus(5'h00, 1'b1, 32'h98A);
		put(16'h03E8, 16'h6D60, 10'h019, 16'h0000, 1'b0);
		cyc(300);
		chk({turn_off_req, power_good_out}, 2'h1, "top current step");
		put(16'h03B5, 16'h6D60, 10'h019, 16'h0000, 1'b0);
		cyc(50);
		chk(power_good_out, 1'b0, "pg lower 95");
		put(16'h03E8, 16'h6D61, 10'h019, 16'h0000, 1'b0);
		cyc(30);
		chk(turn_off_req, 1'b1, "oc trip");
		put(16'h0351, 16'h1388, 10'h019, 16'h0000, 1'b0);
		cyc(300);
		chk({turn_off_req, irq}, 2'h2, "uv trip masked");
		put(16'h044C, 16'h1388, 10'h019, 16'h0000, 1'b0);
		cyc(300);
		chk(turn_off_req, 1'b0, "ov at 110 exact");
		put(16'h044D, 16'h1388, 10'h019, 16'h0000, 1'b0);
		cyc(50);
		chk({turn_off_req, irq}, 2'h3, "ov trip irq");
		put(16'h03E8, 16'h1388, 10'h019, 16'h0000, 1'b0);
		cyc(600);
		chk(turn_off_req, 1'b1, "ov stays latched");
		bus(5'h14, 1'b0, 32'h0);
		chk(rd, 32'hC2, "live latched");
		bus(5'h0C, 1'b0, 32'h0);
		chk(rd & 32'h2, 32'h2, "status ov bit");
		cyc(3);
		chk(irq, 1'b0, "irq cleared by read");
		bus(5'h00, 1'b1, 32'h98A);
		cyc(300);
		chk(turn_off_req, 1'b0, "rearm");
		$display("config test done");
		// Tracking: off by default, then ramp-only with a 250 mV band
		put(16'h03E8, 16'h1388, 10'h019, 16'h0514, 1'b1);
		cyc(50);
		chk(turn_off_req, 1'b0, "tracking disabled");
		bus(5'h00, 1'b1, 32'h220);
		put(16'h03E8, 16'h1388, 10'h019, 16'h0514, 1'b0);
		cyc(50);
		chk(turn_off_req, 1'b0, "no ramp");
		put(16'h03E8, 16'h1388, 10'h019, 16'h04E2, 1'b1);
		cyc(50);
		chk(turn_off_req, 1'b0, "band edge");
		put(16'h03E8, 16'h1388, 10'h019, 16'h02ED, 1'b1);
		cyc(50);
		chk(turn_off_req, 1'b1, "tracking trip");
		put(16'h03E8, 16'h1388, 10'h019, 16'h0000, 1'b0);
		cyc(300);
		// Short excursion of voltage and temperature must be filtered out
		put(16'h0600, 16'h1388, 10'h083, 16'h0000, 1'b0);
		cyc(F - 5);
		put(16'h03E8, 16'h1388, 10'h019, 16'h0000, 1'b0);
		cyc(50);
		chk({turn_off_req, power_good_out, ot_warn}, 3'h2, "glitch");
		$display("tracking and filter test done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
